// file: inc/sgc_map.vh
// register map, field positions, reset values and timing constants
`ifndef SGC_MAP_VH
`define SGC_MAP_VH

// register addresses on the management interface
`define SGC_ADDR_GC3      8'h05
`define SGC_ADDR_GC4      8'h06
`define SGC_ADDR_STL      8'h07
`define SGC_ADDR_FTA      8'h08
`define SGC_ADDR_FTB      8'h09

// reset values
`define SGC_RST_GC3       8'h00
`define SGC_RST_GC4       8'h00
`define SGC_RST_STL       8'h4a
`define SGC_RST_FTA       8'h24
`define SGC_RST_FTB       8'h28
`define SGC_RDATA_NONE    8'h00

// vlan / snoop / scheduling register fields
`define SGC_B_VLAN        7
`define SGC_B_IGMP        6
`define SGC_B_DIRECT      5
`define SGC_B_PRETAG      4
`define SGC_B_PRIO_HI     3
`define SGC_B_PRIO_LO     2
`define SGC_B_TAGMASK     1
`define SGC_B_SNIFF       0

// mii / storm-high register fields
`define SGC_B_BP          7
`define SGC_B_HDX         6
`define SGC_B_FC          5
`define SGC_B_SPD10       4
`define SGC_B_NULLVID     3
`define SGC_B_STH_HI      2
`define SGC_B_STH_LO      0

// priority scheme codes and high-per-low ratios
`define SGC_PRIO_STRICT   2'h0
`define SGC_PRIO_R10      2'h1
`define SGC_PRIO_R5       2'h2
`define SGC_PRIO_R2       2'h3
`define SGC_RATIO_10      4'ha
`define SGC_RATIO_5       4'h5
`define SGC_RATIO_2       4'h2

// switch mii is the last port; tag mask uses the low vid bits
`define SGC_MII_PORT      4
`define SGC_VID_NULL      12'h000

// storm period timing
`define SGC_CLK_MHZ       125
`define SGC_STORM_MS_100  50
`define SGC_STORM_MS_10   500

`endif

// file: hdl/sgc_storm_port.v
// per-port broadcast storm limiter: block counter against threshold
`timescale 1ns/10ps
module sgc_storm_port #(
  parameter TH_W = 11
) (
  input  wire            clk,
  input  wire            sys_rst,
  input  wire            prot_en,
  input  wire            speed_10,
  input  wire            tick_100,
  input  wire            tick_10,
  input  wire [TH_W-1:0] threshold,
  input  wire            bcast_blk,
  output wire            storm_drop
);

  reg  [TH_W-1:0] blk_cnt_ff;
  reg  [TH_W-1:0] nxt_blk_cnt;
  wire            period_end;
  wire            at_limit;

  // period is picked from the port's own speed
  assign period_end = speed_10 ? tick_10 : tick_100;
  assign at_limit   = (blk_cnt_ff >= threshold);

  // count broadcast blocks, saturate, clear at period boundary
  always @* begin
    nxt_blk_cnt = blk_cnt_ff;
    if (period_end) begin
      nxt_blk_cnt = {TH_W{1'b0}};
    end else if (bcast_blk && !at_limit) begin
      nxt_blk_cnt = blk_cnt_ff + {{(TH_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_cnt_ff <= {TH_W{1'b0}};
    end else begin
      blk_cnt_ff <= nxt_blk_cnt;
    end
  end

  // limiting acts only with the port's protection enabled
  assign storm_drop = prot_en & at_limit;

endmodule

// file: hdl/sgc_sched.v
// high/low output queue arbiter with programmable ratio
`timescale 1ns/10ps
`include "sgc_map.vh"
module sgc_sched (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire [1:0] scheme,
  input  wire       hi_pending,
  input  wire       lo_pending,
  input  wire       pick,
  output wire       grant_hi,
  output wire       grant_lo
);

  reg  [3:0] hi_run_ff;
  reg  [3:0] ratio;
  wire       lo_turn;

  // number of high packets allowed before one low packet
  always @* begin
    case (scheme)
      `SGC_PRIO_R10: ratio = `SGC_RATIO_10;
      `SGC_PRIO_R5:  ratio = `SGC_RATIO_5;
      `SGC_PRIO_R2:  ratio = `SGC_RATIO_2;
      default:       ratio = 4'h0;
    endcase
  end

  // low wins when its turn is due or high is idle; strict never forces it
  assign lo_turn  = (scheme != `SGC_PRIO_STRICT) && (hi_run_ff >= ratio);
  assign grant_lo = pick & lo_pending & (lo_turn | ~hi_pending);
  assign grant_hi = pick & hi_pending & ~grant_lo;

  // run length of high grants since the last low grant
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_run_ff <= 4'h0;
    end else if (grant_lo) begin
      hi_run_ff <= 4'h0;
    end else if (grant_hi && hi_run_ff != 4'hf) begin
      hi_run_ff <= hi_run_ff + 4'h1;
    end
  end

endmodule

// file: hdl/sgc_top.v
// switch global control 3..7 register bank with forwarding controls
// Function
// - vlan mode bit enables 802.1q tag forwarding; resets to zero
// - igmp snoop bit sends every igmp packet not received from the switch mii port to that port
// - direct mode forwards mii packets to preamble-named ports, skipping lookup
// - pre-tag prefixes mii-bound packets with their source port number
// - two-bit scheme: strict, or high/low ratios 10:1, 5:1, 2:1
// - tag mask uses the low five vid bits as destination port mask
// - sniff bit set needs both ports to match, clear needs either
// - mii back pressure enable bit, resets to zero
// - mii half duplex when set, full duplex when clear
// - mii full-duplex flow control enable bit
// - mii runs 10 Mbps when set, 100 Mbps when clear
// - duplex, flow control and speed reset from strap pin levels
// - null vid replaced by the port default vid when enabled
// - 11-bit storm threshold of 64-byte blocks split across two registers
// - storm period is 50 ms at 100 Mbps, 500 ms at 10 Mbps
// - storm threshold resets to 0x4a low byte, zero upper bits
// - storm limiting applies only while the port's enable is set
`timescale 1ns/10ps
`include "sgc_map.vh"
module sgc_top #(
  parameter NPORT         = 5,
  parameter CNT_W         = 26,
  parameter STORM_CYC_100 = `SGC_STORM_MS_100 * 1000 * `SGC_CLK_MHZ,
  parameter STORM_CYC_10  = `SGC_STORM_MS_10 * 1000 * `SGC_CLK_MHZ
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire [7:0]       reg_addr,
  input  wire             reg_wr,
  input  wire             reg_rd,
  input  wire [7:0]       reg_wdata,
  output wire [7:0]       reg_rdata,
  input  wire             speed_strap_pin,
  input  wire             duplex_strap_pin,
  input  wire             flow_control_strap_pin,
  output wire             vlan_mode_en,
  output wire             igmp_snoop_en,
  output wire             direct_mode_en,
  output wire             pretag_en,
  output wire             mii_backpressure_en,
  output wire             mii_half_duplex,
  output wire             mii_flow_ctrl_en,
  output wire             mii_speed_10,
  output wire [10:0]      storm_threshold,
  input  wire             pkt_valid,
  input  wire [2:0]       pkt_src_port,
  input  wire             pkt_is_igmp,
  input  wire             pkt_tagged,
  input  wire [11:0]      pkt_vid,
  input  wire [NPORT-1:0] pkt_lookup_mask,
  input  wire [NPORT-1:0] vlan_member_mask,
  input  wire [11:0]      port_default_vid,
  input  wire             switch_port_receive_valid,
  input  wire [NPORT-1:0] direct_dest_mask,
  input  wire             sniff_rx_hit,
  input  wire             sniff_tx_hit,
  output wire             dec_valid,
  output wire [NPORT-1:0] fwd_mask,
  output wire [11:0]      out_vid,
  output wire             mirror,
  output wire             mii_pretag,
  output wire [2:0]       mii_pretag_port,
  input  wire             hi_pending,
  input  wire             lo_pending,
  input  wire             sched_pick,
  output wire             grant_hi,
  output wire             grant_lo,
  input  wire [NPORT-1:0] port_speed_10,
  input  wire [NPORT-1:0] storm_port_en,
  input  wire [NPORT-1:0] bcast_blk,
  output wire [NPORT-1:0] storm_drop
);

  // last count of each period, cut to the timer width on purpose
  localparam [31:0]      CYC_100_M1 = STORM_CYC_100 - 1;
  localparam [31:0]      CYC_10_M1  = STORM_CYC_10 - 1;
  localparam [CNT_W-1:0] LAST_100   = CYC_100_M1[CNT_W-1:0];
  localparam [CNT_W-1:0] LAST_10    = CYC_10_M1[CNT_W-1:0];

  reg  [7:0]       gc3_ff;
  reg  [7:0]       gc4_ff;
  reg  [7:0]       stl_ff;
  reg  [7:0]       fta_ff;
  reg  [7:0]       ftb_ff;
  reg  [7:0]       reg_rdata_ff;
  reg  [7:0]       nxt_rdata;
  reg              strap_done_ff;
  reg  [CNT_W-1:0] per100_ff;
  reg  [CNT_W-1:0] per10_ff;
  reg              tick100_ff;
  reg              tick10_ff;
  reg              dec_valid_ff;
  reg  [NPORT-1:0] fwd_mask_ff;
  reg  [11:0]      out_vid_ff;
  reg              mirror_ff;
  reg              mii_pretag_ff;
  reg  [2:0]       mii_pretag_port_ff;
  reg  [NPORT-1:0] nxt_fwd_mask;
  reg  [11:0]      nxt_out_vid;
  reg              nxt_mirror;
  wire             wr_gc3;
  wire             wr_gc4;
  wire             wr_stl;
  wire             wr_fta;
  wire             wr_ftb;
  wire             from_mii;

  // write strobes per register
  assign wr_gc3 = reg_wr && (reg_addr == `SGC_ADDR_GC3);
  assign wr_gc4 = reg_wr && (reg_addr == `SGC_ADDR_GC4);
  assign wr_stl = reg_wr && (reg_addr == `SGC_ADDR_STL);
  assign wr_fta = reg_wr && (reg_addr == `SGC_ADDR_FTA);
  assign wr_ftb = reg_wr && (reg_addr == `SGC_ADDR_FTB);

  // vlan, snoop, mii-mode and scheduling register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gc3_ff <= `SGC_RST_GC3;
    end else if (wr_gc3) begin
      gc3_ff <= reg_wdata;
    end
  end

  // mii control and storm-high register; straps caught after reset release
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gc4_ff        <= `SGC_RST_GC4;
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
      if (!strap_done_ff) begin
        gc4_ff[`SGC_B_HDX]   <= duplex_strap_pin;
        gc4_ff[`SGC_B_FC]    <= flow_control_strap_pin;
        gc4_ff[`SGC_B_SPD10] <= speed_strap_pin;
      end else if (wr_gc4) begin
        gc4_ff <= reg_wdata;
      end
    end
  end

  // storm-low and factory test registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stl_ff <= `SGC_RST_STL;
      fta_ff <= `SGC_RST_FTA;
      ftb_ff <= `SGC_RST_FTB;
    end else begin
      if (wr_stl) begin
        stl_ff <= reg_wdata;
      end
      if (wr_fta) begin
        fta_ff <= reg_wdata;
      end
      if (wr_ftb) begin
        ftb_ff <= reg_wdata;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    if (reg_addr == `SGC_ADDR_GC3) begin
      nxt_rdata = gc3_ff;
    end else if (reg_addr == `SGC_ADDR_GC4) begin
      nxt_rdata = gc4_ff;
    end else if (reg_addr == `SGC_ADDR_STL) begin
      nxt_rdata = stl_ff;
    end else if (reg_addr == `SGC_ADDR_FTA) begin
      nxt_rdata = fta_ff;
    end else if (reg_addr == `SGC_ADDR_FTB) begin
      nxt_rdata = ftb_ff;
    end else begin
      nxt_rdata = `SGC_RDATA_NONE;
    end
  end

  // read data held until the next read
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= `SGC_RDATA_NONE;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = reg_rdata_ff;

  // configuration outputs straight from register bits
  assign vlan_mode_en        = gc3_ff[`SGC_B_VLAN];
  assign igmp_snoop_en       = gc3_ff[`SGC_B_IGMP];
  assign direct_mode_en      = gc3_ff[`SGC_B_DIRECT];
  assign pretag_en           = gc3_ff[`SGC_B_PRETAG];
  assign mii_backpressure_en = gc4_ff[`SGC_B_BP];
  assign mii_half_duplex     = gc4_ff[`SGC_B_HDX];
  assign mii_flow_ctrl_en    = gc4_ff[`SGC_B_FC];
  assign mii_speed_10        = gc4_ff[`SGC_B_SPD10];
  assign storm_threshold     = {gc4_ff[`SGC_B_STH_HI:`SGC_B_STH_LO], stl_ff};

  // storm period timers for 100 Mbps and 10 Mbps ports
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per100_ff  <= {CNT_W{1'b0}};
      per10_ff   <= {CNT_W{1'b0}};
      tick100_ff <= 1'b0;
      tick10_ff  <= 1'b0;
    end else begin
      tick100_ff <= (per100_ff == LAST_100);
      tick10_ff  <= (per10_ff == LAST_10);
      if (per100_ff == LAST_100) begin
        per100_ff <= {CNT_W{1'b0}};
      end else begin
        per100_ff <= per100_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (per10_ff == LAST_10) begin
        per10_ff <= {CNT_W{1'b0}};
      end else begin
        per10_ff <= per10_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign from_mii = (pkt_src_port == `SGC_MII_PORT) && switch_port_receive_valid;

  // destination mask, vid and mirror decision for one packet
  always @* begin
    nxt_fwd_mask = pkt_lookup_mask;
    nxt_out_vid  = pkt_vid;
    if (direct_mode_en && from_mii) begin
      nxt_fwd_mask = direct_dest_mask;
    end else if (gc3_ff[`SGC_B_TAGMASK] && pkt_tagged) begin
      nxt_fwd_mask = pkt_vid[NPORT-1:0];
    end else if (vlan_mode_en && pkt_tagged) begin
      nxt_fwd_mask = pkt_lookup_mask & vlan_member_mask;
    end
    if (igmp_snoop_en && pkt_is_igmp && !from_mii) begin
      nxt_fwd_mask[`SGC_MII_PORT] = 1'b1;
    end
    if (gc4_ff[`SGC_B_NULLVID] && pkt_tagged && pkt_vid == `SGC_VID_NULL) begin
      nxt_out_vid = port_default_vid;
    end
    if (gc3_ff[`SGC_B_SNIFF]) begin
      nxt_mirror = sniff_rx_hit & sniff_tx_hit;
    end else begin
      nxt_mirror = sniff_rx_hit | sniff_tx_hit;
    end
  end

  // registered decision, one cycle after pkt_valid
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_valid_ff       <= 1'b0;
      fwd_mask_ff        <= {NPORT{1'b0}};
      out_vid_ff         <= `SGC_VID_NULL;
      mirror_ff          <= 1'b0;
      mii_pretag_ff      <= 1'b0;
      mii_pretag_port_ff <= 3'h0;
    end else begin
      dec_valid_ff <= pkt_valid;
      if (pkt_valid) begin
        fwd_mask_ff        <= nxt_fwd_mask;
        out_vid_ff         <= nxt_out_vid;
        mirror_ff          <= nxt_mirror;
        mii_pretag_ff      <= pretag_en & nxt_fwd_mask[`SGC_MII_PORT];
        mii_pretag_port_ff <= pkt_src_port;
      end
    end
  end

  assign dec_valid       = dec_valid_ff;
  assign fwd_mask        = fwd_mask_ff;
  assign out_vid         = out_vid_ff;
  assign mirror          = mirror_ff;
  assign mii_pretag      = mii_pretag_ff;
  assign mii_pretag_port = mii_pretag_port_ff;

  // output queue arbitration by priority scheme
  sgc_sched u_sched (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .scheme     (gc3_ff[`SGC_B_PRIO_HI:`SGC_B_PRIO_LO]),
    .hi_pending (hi_pending),
    .lo_pending (lo_pending),
    .pick       (sched_pick),
    .grant_hi   (grant_hi),
    .grant_lo   (grant_lo)
  );

  // one storm limiter per port
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_storm
      sgc_storm_port #(
        .TH_W (11)
      ) u_storm (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .prot_en    (storm_port_en[gi]),
        .speed_10   (port_speed_10[gi]),
        .tick_100   (tick100_ff),
        .tick_10    (tick10_ff),
        .threshold  (storm_threshold),
        .bcast_blk  (bcast_blk[gi]),
        .storm_drop (storm_drop[gi])
      );
    end
  endgenerate

endmodule

// file: tb/sgc_top_checker.sv
// concurrent checks on the ports of the global control register bank
`timescale 1ns/10ps
module sgc_top_checker #(
  parameter NPORT = 5
) (
  input wire             clk,
  input wire             sys_rst,
  input wire [7:0]       reg_addr,
  input wire             reg_wr,
  input wire             reg_rd,
  input wire [7:0]       reg_wdata,
  input wire [7:0]       reg_rdata,
  input wire             vlan_mode_en,
  input wire             pretag_en,
  input wire             mii_backpressure_en,
  input wire             mii_half_duplex,
  input wire             mii_flow_ctrl_en,
  input wire             mii_speed_10,
  input wire [10:0]      storm_threshold,
  input wire             pkt_valid,
  input wire             dec_valid,
  input wire [NPORT-1:0] fwd_mask,
  input wire             mii_pretag,
  input wire             hi_pending,
  input wire             lo_pending,
  input wire             sched_pick,
  input wire             grant_hi,
  input wire             grant_lo,
  input wire [NPORT-1:0] storm_port_en,
  input wire [NPORT-1:0] storm_drop
);
  // one clock domain, reset masks every check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // level outputs that a read of the mii register must reflect
  wire [6:0] hi_bits = {mii_backpressure_en, mii_half_duplex, mii_flow_ctrl_en, mii_speed_10,
                        storm_threshold[10:8]};
  // write of the vlan register, plain read, packet and its decision
  sequence s_wr;
    reg_wr && reg_addr == 8'h05;
  endsequence
  sequence s_rd(a);
    reg_rd && !reg_wr && reg_addr == a;
  endsequence
  sequence s_dec;
    pkt_valid ##1 dec_valid;
  endsequence
  AST_WR_VLAN: assert property (s_wr |=> vlan_mode_en == $past(reg_wdata[7]))
    else $error("vlan mode bit does not follow the write");
  AST_RD_MII: assert property (s_rd(8'h06) |=> {reg_rdata[7:4], reg_rdata[2:0]} == hi_bits)
    else $error("mii register readback differs from its outputs");
  AST_RD_STL: assert property (s_rd(8'h07) |=> reg_rdata == storm_threshold[7:0])
    else $error("threshold low byte readback differs");
  AST_PRETAG: assert property (s_dec |-> mii_pretag == ($past(pretag_en) && fwd_mask[4]))
    else $error("pre-tag flag wrong for the decision");
  AST_GRANT_ONE: assert property (sched_pick && (hi_pending || lo_pending) |-> grant_hi != grant_lo)
    else $error("pick did not give exactly one grant");
  AST_GRANT_NONE: assert property (!sched_pick || !(hi_pending || lo_pending) |-> !(grant_hi || grant_lo))
    else $error("grant without pick or without pending queue");
  AST_LO_ONLY: assert property (sched_pick && !hi_pending && lo_pending |-> grant_lo)
    else $error("low queue not granted while high is empty");
  AST_STORM_EN: assert property ((storm_drop & ~storm_port_en) == '0)
    else $error("storm drop on a port with protection off");
endmodule

// file: tb/sgc_host.sv
// host model driving the register strobes of the management side
`timescale 1ns/10ps
module sgc_host (
  input  wire        clk,
  input  wire [7:0]  reg_rdata,
  output logic [7:0] reg_addr = 8'h00,
  output logic       reg_wr = 1'b0,
  output logic       reg_rd = 1'b0,
  output logic [7:0] reg_wdata = 8'h00
);
  // one-cycle write; factory registers are restored by the caller
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // one-cycle read; data stands until the next read, taken a cycle later
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule

// file: tb/sgc_top_tb.sv
// self-checking bench for the global control register bank
`timescale 1ns/10ps
module sgc_top_tb;
  logic        clk = 1'b0, sys_rst = 1'b1, pkt_valid = 1'b0, pkt_is_igmp = 1'b0;
  logic        speed_strap_pin = 1'b0, duplex_strap_pin = 1'b1, flow_control_strap_pin = 1'b1;
  logic        pkt_tagged = 1'b0, switch_port_receive_valid = 1'b0, sniff_rx_hit = 1'b0;
  logic        sniff_tx_hit = 1'b0, hi_pending = 1'b0, lo_pending = 1'b0, sched_pick = 1'b0;
  logic [2:0]  pkt_src_port = 3'h0;
  logic [11:0] pkt_vid = 12'h000, port_default_vid = 12'h123;
  logic [4:0]  pkt_lookup_mask = 5'h06, vlan_member_mask = 5'h1f, direct_dest_mask = 5'h09;
  logic [4:0]  port_speed_10 = 5'h02, storm_port_en = 5'h03, bcast_blk = 5'h00;
  wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
  wire         reg_wr, reg_rd, vlan_mode_en, igmp_snoop_en, direct_mode_en, pretag_en;
  wire         mii_backpressure_en, mii_half_duplex, mii_flow_ctrl_en, mii_speed_10;
  wire         dec_valid, mirror, mii_pretag, grant_hi, grant_lo;
  wire  [10:0] storm_threshold;
  wire  [4:0]  fwd_mask, storm_drop;
  wire  [11:0] out_vid;
  wire  [2:0]  mii_pretag_port;
  int          fail_count = 0, checks_done = 0, i, k, n;
  // address, write data, expected readback; factory registers restored last
  logic [23:0] rows [0:8] = '{24'h05a5a5, 24'h06f7f7, 24'h071313, 24'h085a5a, 24'h09c3c3,
                              24'h0a7700, 24'h041100, 24'h082424, 24'h092828};
  logic [7:0]  rst_val [0:4] = '{8'h00, 8'h60, 8'h4a, 8'h24, 8'h28};

  sgc_top #(.STORM_CYC_100(50), .STORM_CYC_10(500)) i_dut (
    .clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .speed_strap_pin,
    .duplex_strap_pin, .flow_control_strap_pin, .vlan_mode_en, .igmp_snoop_en, .direct_mode_en,
    .pretag_en, .mii_backpressure_en, .mii_half_duplex, .mii_flow_ctrl_en, .mii_speed_10,
    .storm_threshold, .pkt_valid, .pkt_src_port, .pkt_is_igmp, .pkt_tagged, .pkt_vid,
    .pkt_lookup_mask, .vlan_member_mask, .port_default_vid, .switch_port_receive_valid,
    .direct_dest_mask, .sniff_rx_hit, .sniff_tx_hit, .dec_valid, .fwd_mask, .out_vid, .mirror,
    .mii_pretag, .mii_pretag_port, .hi_pending, .lo_pending, .sched_pick, .grant_hi, .grant_lo,
    .port_speed_10, .storm_port_en, .bcast_blk, .storm_drop);
  sgc_host i_host (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

  // 125 MHz clock
  always #4 clk = ~clk;

  // compare of a decision, grant or status value
  task chk_out(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // register read and compare
  task rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    checks_done++;
    if (d !== e) begin
      fail_count++;
      $display("Error at %0t: reg %h read %h, expected %h", $time, a, d, e);
    end
  endtask
  // one packet decision request
  task go;
    @(negedge clk);
    pkt_valid = 1'b1;
    @(negedge clk);
    pkt_valid = 1'b0;
  endtask
  task report_and_stop;
    $display("checks %0d, errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    for (i = 0; i < 5; i++) rdc(8'h05 + i[7:0], rst_val[i]);
    for (i = 0; i < 9; i++) begin
      i_host.wr(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    chk_out(storm_threshold, 12'h713);
    i_host.wr(8'h05, 8'h02);
    pkt_tagged = 1'b1;
    pkt_vid = 12'h013;
    go;
    chk_out(fwd_mask, 12'h013);
    pkt_vid = 12'h000;
    go;
    chk_out(out_vid, 12'h000);
    i_host.wr(8'h06, 8'h08);
    go;
    chk_out(out_vid, 12'h123);
    i_host.wr(8'h05, 8'h20);
    chk_out({vlan_mode_en, igmp_snoop_en, direct_mode_en, pretag_en}, 12'h002);
    pkt_tagged = 1'b0;
    pkt_src_port = 3'h4;
    switch_port_receive_valid = 1'b1;
    go;
    chk_out(fwd_mask, 12'h009);
    switch_port_receive_valid = 1'b0;
    go;
    chk_out(fwd_mask, 12'h006);
    i_host.wr(8'h05, 8'h50);
    chk_out({vlan_mode_en, igmp_snoop_en, direct_mode_en, pretag_en}, 12'h005);
    pkt_src_port = 3'h1;
    pkt_is_igmp = 1'b1;
    go;
    chk_out(fwd_mask, 12'h016);
    chk_out({mii_pretag, mii_pretag_port}, 12'h009);
    i_host.wr(8'h05, 8'h01);
    pkt_is_igmp = 1'b0;
    sniff_rx_hit = 1'b1;
    go;
    chk_out({mii_pretag, mirror, fwd_mask}, 12'h006);
    i_host.wr(8'h05, 8'h00);
    go;
    chk_out(mirror, 12'h001);
    vlan_member_mask = 5'h02;
    pkt_tagged = 1'b1;
    i_host.wr(8'h05, 8'h80);
    go;
    chk_out({dec_valid, fwd_mask}, 12'h022);
    // scheduling: low first to restart the run, then high runs per scheme
    for (i = 0; i < 4; i++) begin
      i_host.wr(8'h05, {4'h0, i[1:0], 2'h0});
      n = (i == 0) ? 12 : (i == 1) ? 10 : (i == 2) ? 5 : 2;
      @(negedge clk);
      sched_pick = 1'b1;
      lo_pending = 1'b1;
      hi_pending = 1'b0;
      #1 chk_out({grant_hi, grant_lo}, 12'h001);
      for (k = 0; k <= n; k++) begin
        @(negedge clk);
        hi_pending = 1'b1;
        #1 chk_out({grant_hi, grant_lo}, (k == n && i != 0) ? 12'h001 : 12'h002);
      end
      sched_pick = 1'b0;
    end
    // storm: align to a period edge, then count to threshold and time the period
    i_host.wr(8'h06, 8'h00);
    i_host.wr(8'h07, 8'h02);
    for (i = 0; i < 2; i++) begin
      n = i ? 500 : 50;
      bcast_blk[i] = 1'b1;
      for (k = 0; k < 8 && storm_drop[i] !== 1'b1; k++) @(negedge clk);
      bcast_blk[i] = 1'b0;
      for (k = 0; k < 600 && storm_drop[i] !== 1'b0; k++) @(negedge clk);
      bcast_blk[i] = 1'b1;
      @(negedge clk);
      chk_out(storm_drop[i], 12'h000);
      @(negedge clk);
      bcast_blk[i] = 1'b0;
      chk_out(storm_drop[i], 12'h001);
      for (k = 2; k < 600 && storm_drop[i] !== 1'b0; k++) @(negedge clk);
      chk_out(k[11:0], n[11:0]);
    end
    // both periods just restarted: fill ports 0..2, port 2 has protection off
    bcast_blk = 5'h07;
    repeat (3) @(negedge clk);
    bcast_blk = 5'h00;
    chk_out(storm_drop, 12'h003);
    storm_port_en = 5'h00;
    #1 chk_out(storm_drop, 12'h000);
    // second reset with other strap levels
    speed_strap_pin = 1'b1;
    duplex_strap_pin = 1'b0;
    flow_control_strap_pin = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk_out(storm_threshold, 12'h04a);
    repeat (2) @(negedge clk);
    rdc(8'h05, 8'h00);
    rdc(8'h06, 8'h10);
    report_and_stop;
  end

  // watchdog far beyond the expected run length
  initial begin
    #200000;
    fail_count++;
    report_and_stop;
  end
endmodule

// checker attached to the top module
bind sgc_top sgc_top_checker #(.NPORT(NPORT)) i_chk (
  .clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .vlan_mode_en,
  .pretag_en, .mii_backpressure_en, .mii_half_duplex, .mii_flow_ctrl_en, .mii_speed_10,
  .storm_threshold, .pkt_valid, .dec_valid, .fwd_mask, .mii_pretag, .hi_pending, .lo_pending,
  .sched_pick, .grant_hi, .grant_lo, .storm_port_en, .storm_drop);
